// ==== core/vfp_ctrl.sv ====
// Vectored fixed-priority interrupt controller with an AHB-Lite register slave.
// Assumes the core samples accept_out at each instruction boundary and pulses
// accept_strobe_in when it takes the offered vector; timer pulses share clk_in.
// Contract
// - Eight vectors serve eight sources: four external, three internal, one software.
// - Every source except reset and software break owns a request bit and an enable bit.
// - Maskable acceptance needs request one, enable one and disable flag zero.
// - Priority order is fixed in hardware; software steers only enables and flag.
// - Reset is non-maskable, highest priority, vector pair FFFD and FFFC.
// - Key wakeup, priority 2, FFFB/FFFA, from AND of selected input pins.
// - Pin interrupt zero, priority 3, FFF9/FFF8, on its selected edge.
// - Pin interrupt one, priority 4, FFF7/FFF6, on its selected edge.
// - Second timer underflow requests at priority 5, vectors FFF5/FFF4.
// - Third timer underflow requests at priority 6, vectors FFF3/FFF2.
// - First timer underflow requests at priority 7, FFF1/FFF0, ends stop release.
// - Software break is non-maskable, lowest priority 8, vectors FFDD/FFDC.
// - Each vector pair gives the routine address as high and low bytes.
// - Request bits stay set until accepted; software clears but never sets them.
// - Highest pending request wins; others keep their bits for next acceptance.
// - Acceptance follows instruction end, clears the request, core sets flag.
// - Disable flag is processor status bit 2 and blocks all but reset and break.
//
// The AHB-Lite register port and the address map were decided locally.
`default_nettype none

module vfp_ctrl (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Pins
  input wire logic [vfp_pkg::PORT_WIDTH-1:0] first_port_pins_in,
  input wire logic [vfp_pkg::PORT_WIDTH-1:0] first_port_dir_in,
  input wire logic ext_pin_irq_zero_in,
  input wire logic ext_pin_irq_one_in,
  // Timer underflow pulses
  input wire vfp_pkg::vfp_tmr_t tmr_underflow_in,
  // Core side
  input wire logic [7:0] core_status_in,
  input wire logic software_break_instr_in,
  input wire logic accept_strobe_in,
  output vfp_pkg::vfp_accept_t accept_out,
  output logic stop_release_out,
  output logic irq_out
);
  import vfp_pkg::*;

  vfp_state_t state_reg;
  vfp_state_t state_next;

  logic [SYNC_WIDTH-1:0] pins_sync;
  logic [PORT_WIDTH-1:0] key_pins;
  logic [PORT_WIDTH-1:0] key_active;
  logic key_and;
  logic int0_level;
  logic ext_pin_irq_one_level;
  logic [REQ_COUNT-1:0] req_event;
  logic [REQ_COUNT-1:0] req_taken;
  logic [REQ_COUNT-1:0] req_sw_clear;
  logic [REQ_COUNT-1:0] req_after;
  logic [REQ_COUNT-1:0] req_ready;
  logic iflag;
  logic addr_phase;
  logic wr_req_now;
  vfp_src_t sel_src;
  logic sel_valid;
  logic [31:0] rd_value;

  // Pins cross into the clock domain first
  vfp_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({ext_pin_irq_one_in, ext_pin_irq_zero_in, first_port_pins_in}),
    .sync_out(pins_sync)
  );

  assign key_pins = pins_sync[PORT_WIDTH-1:0];
  assign int0_level = pins_sync[SYNC_INT0_BIT];
  assign ext_pin_irq_one_level = pins_sync[SYNC_EXT_PIN_IRQ_ONE_BIT];

  // Key wakeup level: AND over selected pins that are inputs, others read as one
  assign key_active = state_reg.key_pin_sel & ~first_port_dir_in;
  assign key_and = &(key_pins | ~key_active);

  // Source events; edges are ignored until the pin history is valid
  always_comb begin
    req_event = '0;
    if (state_reg.pins_primed == PRIME_DONE) begin
      if (state_reg.key_edge_sel) begin
        req_event[BIT_KEY] = key_and & ~state_reg.key_and_prev;
      end else begin
        req_event[BIT_KEY] = ~key_and & state_reg.key_and_prev;
      end
      if (state_reg.edge_sel[EDGE_INT0_BIT]) begin
        req_event[BIT_INT0] = int0_level & ~state_reg.int0_prev;
      end else begin
        req_event[BIT_INT0] = ~int0_level & state_reg.int0_prev;
      end
      if (state_reg.edge_sel[EDGE_EXT_PIN_IRQ_ONE_BIT]) begin
        req_event[BIT_EXT_PIN_IRQ_ONE] = ext_pin_irq_one_level & ~state_reg.ext_pin_irq_one_prev;
      end else begin
        req_event[BIT_EXT_PIN_IRQ_ONE] = ~ext_pin_irq_one_level & state_reg.ext_pin_irq_one_prev;
      end
    end
    req_event[BIT_TMR2] = tmr_underflow_in.tmr2;
    req_event[BIT_TMR3] = tmr_underflow_in.tmr3;
    req_event[BIT_TMR1] = tmr_underflow_in.tmr1;
  end

  // Disable flag from the core status byte
  assign iflag = core_status_in[PS_IFLAG_BIT];

  // Maskable requests eligible for acceptance
  assign req_ready = state_reg.req & state_reg.enable & {REQ_COUNT{~iflag}};

  // Fixed priority select: reset, then maskable in bit order, then break
  always_comb begin
    sel_src = SRC_BREAK;
    sel_valid = 1'b0;
    if (state_reg.reset_pend) begin
      sel_src = SRC_RESET;
      sel_valid = 1'b1;
    end else if (|req_ready) begin
      sel_valid = 1'b1;
      for (int k = REQ_COUNT - 1; k >= 0; k--) begin
        if (req_ready[k]) begin
          sel_src = vfp_src_t'(3'(k + 1));
        end
      end
    end else if (state_reg.break_pend) begin
      sel_src = SRC_BREAK;
      sel_valid = 1'b1;
    end
  end

  // Answer to the core, recomputed every cycle
  always_comb begin
    accept_out.pending = sel_valid;
    accept_out.src = sel_src;
    accept_out.vec_hi_addr = VEC_HI[sel_src];
    accept_out.vec_lo_addr = VEC_LO[sel_src];
  end

  // Bit cleared by an acceptance of its own source
  always_comb begin
    req_taken = '0;
    if (accept_strobe_in && sel_valid && sel_src != SRC_RESET && sel_src != SRC_BREAK) begin
      req_taken[3'(sel_src) - 3'h1] = 1'b1;
    end
  end

  // Software write of a one clears a request bit
  always_comb begin
    req_sw_clear = '0;
    if (state_reg.wr_pend && state_reg.wr_addr == OFS_REQ) begin
      req_sw_clear = hwdata_in[REQ_COUNT-1:0];
    end
  end

  // Per-bit request update; a new event wins over any clear
  genvar b;
  generate
    for (b = 0; b < REQ_COUNT; b++) begin : g_req
      assign req_after[b] = req_event[b] | (state_reg.req[b] & ~req_taken[b] & ~req_sw_clear[b]);
    end
  endgenerate

  // Bus address phase detection
  assign addr_phase = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ;
  assign wr_req_now = addr_phase && hwrite_in && hsize_in == HSIZE_WORD;

  // Read value for the addressed register; unmapped reads as zero
  always_comb begin
    rd_value = '0;
    case (haddr_in)
      OFS_REQ: begin
        rd_value[REQ_COUNT-1:0] = state_reg.req;
      end
      OFS_ENABLE: begin
        rd_value[REQ_COUNT-1:0] = state_reg.enable;
      end
      OFS_EDGE: begin
        rd_value[1:0] = state_reg.edge_sel;
      end
      OFS_KEY_PIN: begin
        rd_value[PORT_WIDTH-1:0] = state_reg.key_pin_sel;
      end
      OFS_KEY_EDGE: begin
        rd_value[0] = state_reg.key_edge_sel;
      end
      OFS_SELECT: begin
        rd_value[3] = sel_valid;
        rd_value[2:0] = sel_src;
      end
      default: begin
        rd_value = '0;
      end
    endcase
  end

  // Next state of the controller
  always_comb begin
    state_next = state_reg;
    state_next.req = req_after;
    state_next.key_and_prev = key_and;
    state_next.int0_prev = int0_level;
    state_next.ext_pin_irq_one_prev = ext_pin_irq_one_level;
    // Synchroniser reset levels must not look like a pin edge
    if (state_reg.pins_primed != PRIME_DONE) begin
      state_next.pins_primed = state_reg.pins_primed + 2'h1;
    end
    state_next.stop_release = tmr_underflow_in.tmr1;
    // Reset vector stays offered until the core takes it
    if (accept_strobe_in && sel_valid && sel_src == SRC_RESET) begin
      state_next.reset_pend = 1'b0;
    end
    // Break is held until taken; a new break in the same cycle keeps it
    if (accept_strobe_in && sel_valid && sel_src == SRC_BREAK) begin
      state_next.break_pend = 1'b0;
    end
    if (software_break_instr_in) begin
      state_next.break_pend = 1'b1;
    end
    // Write data phase
    state_next.wr_pend = wr_req_now;
    if (wr_req_now) begin
      state_next.wr_addr = haddr_in;
    end
    if (state_reg.wr_pend) begin
      case (state_reg.wr_addr)
        OFS_ENABLE: begin
          state_next.enable = hwdata_in[REQ_COUNT-1:0];
        end
        OFS_EDGE: begin
          state_next.edge_sel = hwdata_in[1:0];
        end
        OFS_KEY_PIN: begin
          state_next.key_pin_sel = hwdata_in[PORT_WIDTH-1:0];
        end
        OFS_KEY_EDGE: begin
          state_next.key_edge_sel = hwdata_in[0];
        end
        default: begin
          // Request clears and unmapped offsets are handled elsewhere
        end
      endcase
    end
    // Read data captured at the address phase
    if (addr_phase && !hwrite_in) begin
      state_next.rdata = rd_value;
    end
  end

  // Register the state; reset offers the reset vector
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.req <= RST_REQ;
      state_reg.enable <= RST_ENABLE;
      state_reg.edge_sel <= RST_EDGE;
      state_reg.key_pin_sel <= RST_KEY_PIN;
      state_reg.key_edge_sel <= RST_KEY_EDGE;
      state_reg.reset_pend <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = state_reg.rdata;
  assign stop_release_out = state_reg.stop_release;
  assign irq_out = |(state_reg.req & state_reg.enable);

endmodule : vfp_ctrl

`default_nettype wire

// ==== core/vfp_pkg.sv ====
// Package for the vectored fixed-priority interrupt controller.
// Holds register offsets, field positions, reset values, vectors and state records.
// Assumes a single 125 MHz core clock and a synchronous active-low reset.
`default_nettype none

package vfp_pkg;

  // Number of vectored sources, reset and software break included
  localparam int unsigned SRC_COUNT = 8;
  // Number of maskable sources that own a request and an enable bit
  localparam int unsigned REQ_COUNT = 6;
  localparam int unsigned PORT_WIDTH = 8;
  // Pins seen by the synchroniser: first port, then pin zero, then pin one
  localparam int unsigned SYNC_WIDTH = 10;
  localparam int unsigned SYNC_INT0_BIT = 8;
  localparam int unsigned SYNC_EXT_PIN_IRQ_ONE_BIT = 9;

  // Request and enable bit positions
  localparam int unsigned BIT_KEY = 0;
  localparam int unsigned BIT_INT0 = 1;
  localparam int unsigned BIT_EXT_PIN_IRQ_ONE = 2;
  localparam int unsigned BIT_TMR2 = 3;
  localparam int unsigned BIT_TMR3 = 4;
  localparam int unsigned BIT_TMR1 = 5;

  // Edge selection field positions; a one selects the rising edge
  localparam int unsigned EDGE_INT0_BIT = 0;
  localparam int unsigned EDGE_EXT_PIN_IRQ_ONE_BIT = 1;

  // Core processor status bit that blocks maskable acceptance
  localparam int unsigned PS_IFLAG_BIT = 2;

  // Priming count at which both synchroniser stages and the edge history hold real pin levels
  localparam logic [1:0] PRIME_DONE = 2'h3;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_REQ = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_EDGE = 8'h08;
  localparam logic [7:0] OFS_KEY_PIN = 8'h0C;
  localparam logic [7:0] OFS_KEY_EDGE = 8'h10;
  localparam logic [7:0] OFS_SELECT = 8'h14;

  // Reset values
  localparam logic [5:0] RST_REQ = 6'h00;
  localparam logic [5:0] RST_ENABLE = 6'h00;
  localparam logic [1:0] RST_EDGE = 2'h0;
  localparam logic [7:0] RST_KEY_PIN = 8'h00;
  localparam logic RST_KEY_EDGE = 1'b0;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Source identifiers in priority order, highest first
  typedef enum logic [2:0] {
    SRC_RESET = 3'b000,
    SRC_KEY = 3'b001,
    SRC_INT0 = 3'b010,
    SRC_EXT_PIN_IRQ_ONE = 3'b011,
    SRC_TMR2 = 3'b100,
    SRC_TMR3 = 3'b101,
    SRC_TMR1 = 3'b110,
    SRC_BREAK = 3'b111
  } vfp_src_t;

  // Vector pair addresses, indexed by source identifier
  localparam logic [15:0] VEC_HI [SRC_COUNT] = '{16'hFFFD, 16'hFFFB, 16'hFFF9, 16'hFFF7,
                                                 16'hFFF5, 16'hFFF3, 16'hFFF1, 16'hFFDD};
  localparam logic [15:0] VEC_LO [SRC_COUNT] = '{16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6,
                                                 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFDC};

  // Timer underflow pulses from the timer block
  typedef struct packed {
    logic tmr1;
    logic tmr2;
    logic tmr3;
  } vfp_tmr_t;

  // Answer to the core at an acceptance point
  typedef struct packed {
    logic pending;
    vfp_src_t src;
    logic [15:0] vec_hi_addr;
    logic [15:0] vec_lo_addr;
  } vfp_accept_t;

  // Synchroniser state
  typedef struct packed {
    logic [SYNC_WIDTH-1:0] stage1;
    logic [SYNC_WIDTH-1:0] stage2;
  } vfp_sync_state_t;

  // Controller state
  typedef struct packed {
    logic [REQ_COUNT-1:0] req;
    logic [REQ_COUNT-1:0] enable;
    logic [1:0] edge_sel;
    logic [PORT_WIDTH-1:0] key_pin_sel;
    logic key_edge_sel;
    logic key_and_prev;
    logic int0_prev;
    logic ext_pin_irq_one_prev;
    logic [1:0] pins_primed;
    logic reset_pend;
    logic break_pend;
    logic stop_release;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } vfp_state_t;

endpackage : vfp_pkg

`default_nettype wire

// ==== core/vfp_sync.sv ====
// Two-flip-flop synchroniser for the pins of the interrupt controller.
// Assumes the pins are asynchronous to clk_in; only stage two is read outside.
`default_nettype none

module vfp_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [vfp_pkg::SYNC_WIDTH-1:0] async_in,
  output logic [vfp_pkg::SYNC_WIDTH-1:0] sync_out
);
  import vfp_pkg::*;

  vfp_sync_state_t state_reg;
  vfp_sync_state_t state_next;
  logic [SYNC_WIDTH-1:0] stage1_next;

  // One flip-flop pair per pin
  genvar i;
  generate
    for (i = 0; i < SYNC_WIDTH; i++) begin : g_bit
      assign stage1_next[i] = async_in[i];
    end
  endgenerate

  // Next state: first stage feeds the second and nothing else
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = stage1_next;
    state_next.stage2 = state_reg.stage1;
  end

  // Register the state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule : vfp_sync

`default_nettype wire

// ==== tb/vfp_ctrl_properties.sv ====
// Checker for the core-side outputs of the interrupt controller.
// Assumes it is bound into vfp_ctrl and sees only that module's ports.
`default_nettype none

module vfp_ctrl_properties
  import vfp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [7:0] core_status_in,
  input wire logic software_break_instr_in,
  input wire logic accept_strobe_in,
  input wire vfp_pkg::vfp_tmr_t tmr_underflow_in,
  input wire vfp_pkg::vfp_accept_t accept_out,
  input wire logic stop_release_out,
  input wire logic irq_out
);
  logic flag;
  logic mask_src;

  // Disable flag and whether the offered source is maskable
  assign flag = core_status_in[PS_IFLAG_BIT];
  assign mask_src = (accept_out.src != SRC_RESET) && (accept_out.src != SRC_BREAK);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Vector, priority and hold relations of the offered source
  AST_VEC: assert property (accept_out.pending |->
    accept_out.vec_hi_addr == VEC_HI[accept_out.src] && accept_out.vec_lo_addr == VEC_LO[accept_out.src])
    else $error("offered vector does not match source");
  AST_FLAG: assert property (accept_out.pending && flag |-> !mask_src)
    else $error("maskable source offered while flag set");
  AST_IRQ: assert property (accept_out.pending && mask_src |-> irq_out)
    else $error("maskable source offered without enabled request");
  AST_BRK_LOW: assert property (accept_out.pending && accept_out.src == SRC_BREAK |-> !(irq_out && !flag))
    else $error("break offered over an eligible request");
  AST_BRK: assert property (software_break_instr_in |=> accept_out.pending)
    else $error("break not held pending");
  AST_RST_ROSE: assert property ($rose(rst_n_in) |-> accept_out.pending && accept_out.src == SRC_RESET)
    else $error("reset vector not offered after reset");
  AST_RST_HOLD: assert property (accept_out.pending && accept_out.src == SRC_RESET && !accept_strobe_in
    |=> accept_out.pending && accept_out.src == SRC_RESET)
    else $error("reset vector dropped before acceptance");
  AST_KEEP: assert property (accept_out.pending && !accept_strobe_in && !hsel_in && !$past(hsel_in) && !flag
    |=> accept_out.pending || flag)
    else $error("pending request lost without acceptance");
  AST_STOP: assert property (tmr_underflow_in.tmr1 |=> stop_release_out)
    else $error("stop release pulse missing");

  // Main scenarios
  COV_TMR2: cover property (accept_strobe_in && accept_out.src == SRC_TMR2);
  COV_BRK: cover property (accept_strobe_in && accept_out.src == SRC_BREAK);
  COV_STOP: cover property (stop_release_out);
endmodule : vfp_ctrl_properties

bind vfp_ctrl vfp_ctrl_properties u_props (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .hsel_in(hsel_in),
  .core_status_in(core_status_in),
  .software_break_instr_in(software_break_instr_in),
  .accept_strobe_in(accept_strobe_in),
  .tmr_underflow_in(tmr_underflow_in),
  .accept_out(accept_out),
  .stop_release_out(stop_release_out),
  .irq_out(irq_out)
);

`default_nettype wire

// ==== tb/vfp_core_model.sv ====
// Core model: takes offered vectors up to a wanted count and logs them.
// Assumes accept_in is settled before each rising edge of clk_in.
`default_nettype none

module vfp_core_model
  import vfp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input var int want_in,
  input wire vfp_pkg::vfp_accept_t accept_in,
  output logic strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] src_q[$];
  logic [15:0] hi_q[$];

  // One take per instruction end, then a gap cycle before the next
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      strobe_out <= 1'b0;
    end else if (strobe_out) begin
      strobe_out <= 1'b0;
      src_q.push_back(accept_in.src);
      hi_q.push_back(accept_in.vec_hi_addr);
    end else if (src_q.size() < want_in && accept_in.pending) begin
      strobe_out <= 1'b1;
    end
  end
endmodule : vfp_core_model

`default_nettype wire

// ==== tb/tb_vectored_fixed_priority_irq.sv ====
// Testbench for vfp_ctrl: AHB-Lite master tasks, core model, scenarios.
// Assumes a zero-wait slave; pins change only just after a rising edge.
`default_nettype none

module tb_vectored_fixed_priority_irq;
  import vfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hrdy;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] pins = 8'hFF;
  logic [7:0] dir = 8'h00;
  logic p0 = 1'b1;
  logic p1 = 1'b1;
  vfp_tmr_t tmr = '0;
  logic [7:0] ps = 8'h00;
  logic software_break_instr = 1'b0;
  logic stb;
  logic stop;
  logic irq;
  vfp_accept_t acc;
  int want = 0;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rd;

  vfp_ctrl DUT (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .hsel_in(hsel),
    .haddr_in(haddr),
    .htrans_in(htrans),
    .hwrite_in(hwrite),
    .hsize_in(HSIZE_WORD),
    .hwdata_in(hwdata),
    .hready_in(hrdy),
    .hreadyout_out(hrdy),
    .hresp_out(hresp),
    .hrdata_out(hrdata),
    .first_port_pins_in(pins),
    .first_port_dir_in(dir),
    .ext_pin_irq_zero_in(p0),
    .ext_pin_irq_one_in(p1),
    .tmr_underflow_in(tmr),
    .core_status_in(ps),
    .software_break_instr_in(software_break_instr),
    .accept_strobe_in(stb),
    .accept_out(acc),
    .stop_release_out(stop),
    .irq_out(irq)
  );

  vfp_core_model core (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .want_in(want),
    .accept_in(acc),
    .strobe_out(stb)
  );

  // Clock and hang guard
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Single AHB-Lite transfer; read data taken at the end of the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // Lets the core model take vectors until n have been logged
  task automatic take_to(input int n);
    want <= n;
    for (int i = 0; i < 300 && core.src_q.size() < n; i++) @(posedge clk_in);
    chk("takes", 32'(core.src_q.size()), 32'(n));
  endtask : take_to

  task automatic t_reset();
    cyc(1);
    chk("pend", 32'(acc.pending), 32'h1);
    chk("vec", {acc.vec_hi_addr, acc.vec_lo_addr}, 32'hFFFDFFFC);
    chk("irq", 32'(irq), 32'h0);
    rchk("req", OFS_REQ, 32'h0);
    rchk("en", OFS_ENABLE, 32'h0);
    rchk("sel", OFS_SELECT, 32'h8);
    rchk("unmapped", 8'h20, 32'h0);
    take_to(1);
    chk("rsrc", 32'(core.src_q[0]), 32'(SRC_RESET));
  endtask : t_reset

  // Every maskable source at once under the flag, then served in order
  task automatic t_all();
    ps <= 8'h04;
    bus(1'b1, OFS_ENABLE, 32'h3F);
    bus(1'b1, OFS_KEY_PIN, 32'h1);
    pins <= 8'h00;
    p0 <= 1'b0;
    p1 <= 1'b0;
    tmr <= 3'h7;
    cyc(1);
    tmr <= 3'h0;
    cyc(1);
    chk("stop", 32'(stop), 32'h1);
    cyc(5);
    chk("pend", 32'(acc.pending), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    rchk("req", OFS_REQ, 32'h3F);
    ps <= 8'h00;
    take_to(7);
    for (int k = 1; k < 7; k++) begin
      chk("src", 32'(core.src_q[k]), 32'(k));
      chk("hi", 32'(core.hi_q[k]), 32'(16'hFFFD - 2 * k));
    end
    rchk("req", OFS_REQ, 32'h0);
  endtask : t_all

  // Disabled source keeps its bit; software clears it, a zero does nothing
  task automatic t_mask();
    bus(1'b1, OFS_ENABLE, 32'h2F);
    tmr <= 3'h1;
    cyc(1);
    tmr <= 3'h0;
    cyc(2);
    chk("pend", 32'(acc.pending), 32'h0);
    rchk("req", OFS_REQ, 32'h10);
    bus(1'b1, OFS_REQ, 32'h0);
    rchk("req", OFS_REQ, 32'h10);
    bus(1'b1, OFS_REQ, 32'h10);
    rchk("req", OFS_REQ, 32'h0);
  endtask : t_mask

  // Break passes the flag, then yields to a higher eligible request
  task automatic t_break();
    bus(1'b1, OFS_ENABLE, 32'h3F);
    ps <= 8'h04;
    software_break_instr <= 1'b1;
    tmr <= 3'h2;
    cyc(1);
    software_break_instr <= 1'b0;
    tmr <= 3'h0;
    cyc(2);
    chk("vec", {acc.vec_hi_addr, acc.vec_lo_addr}, 32'hFFDDFFDC);
    ps <= 8'h00;
    cyc(1);
    chk("src", 32'(acc.src), 32'(SRC_TMR2));
    take_to(9);
    chk("src", 32'(core.src_q[7]), 32'(SRC_TMR2));
    chk("src", 32'(core.src_q[8]), 32'(SRC_BREAK));
  endtask : t_break

  // Rising edge on both pins and on the key AND; key pin zero is an output and is left out
  task automatic t_edge();
    bus(1'b1, OFS_ENABLE, 32'h0);
    bus(1'b1, OFS_EDGE, 32'h3);
    bus(1'b1, OFS_KEY_EDGE, 32'h1);
    bus(1'b1, OFS_KEY_PIN, 32'h3);
    dir <= 8'h01;
    bus(1'b1, OFS_REQ, 32'h3F);
    p0 <= 1'b1;
    p1 <= 1'b1;
    pins <= 8'h02;
    cyc(6);
    rchk("req", OFS_REQ, 32'h7);
    rchk("edge", OFS_EDGE, 32'h3);
    rchk("kedge", OFS_KEY_EDGE, 32'h1);
    rchk("kpin", OFS_KEY_PIN, 32'h3);
  endtask : t_edge

  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_all();
    t_mask();
    t_break();
    t_edge();
    tally_and_finish();
  end
endmodule : tb_vectored_fixed_priority_irq

`default_nettype wire
